// file: hdl/flr_regs.sv
// FIFO latency status register bank with AXI4-Lite slave.
// Assumes measurement results arrive already synchronised to CLK as one-cycle update strobes.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
// Notes on behaviour
// (RULE1) TX PCS latency in bits 24:16, reset zero
// (RULE2) TX core latency in bits 8:0, reset zero
// (RULE3) RX PCS latency in bits 24:16, reset zero
// (RULE4) RX core latency in bits 8:0, reset zero
// (RULE5) Count is latency in 1/128 clock-period steps
// (RULE6) Bits 31/15 flag PCS/core update, reset zero
// (RULE7) Bank present only in one build variant
// (RULE8) Version: major 7:4, minor 3:0, rest reserved
// (RULE9) Version 6.1 encodes as 0110_0001
// (RULE10) Version is constant, untouched by reset
// (RULE11) Reserved bits read zero, writes ignored
module flr_regs
    import flr_pkg::*;
#(
    parameter bit BANK_PRESENT = 1'b1
) (
    input wire logic CLK,
    input wire logic RST,
    input wire flr_meas_t TX_PCS_MEAS,
    input wire flr_meas_t TX_CORE_MEAS,
    input wire flr_meas_t RX_PCS_MEAS,
    input wire flr_meas_t RX_CORE_MEAS,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic IRQ
);
    flr_lat_t tx_fifo_latency;
    flr_lat_t rx_fifo_latency;
    logic [3:0] int_stat;
    logic [3:0] int_mask;
    logic [3:0] upd_vec;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    flr_wst_t wst;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic [7:0] ver_word;
    logic stat_wr;

    // Version is a wired constant, so no reset reaches it
    assign ver_word = {FLR_VER_MAJOR, FLR_VER_MINOR}; // [RULE8] [RULE9] [RULE10]
    assign upd_vec = {RX_CORE_MEAS.upd, RX_PCS_MEAS.upd, TX_CORE_MEAS.upd, TX_PCS_MEAS.upd};

    // Counts are taken as given; each step is 1/FLR_STEPS_PER_PERIOD of a sample clock period [RULE5]
    // Transmit latency capture: count and fresh flag load together
    always_ff @(posedge CLK) begin
        if (RST) begin
            tx_fifo_latency <= '0; // [RULE1] [RULE2] [RULE6]
        end else begin
            if (TX_PCS_MEAS.upd) begin
                tx_fifo_latency.pcs_cnt <= TX_PCS_MEAS.cnt; // [RULE1]
                tx_fifo_latency.pcs_vld <= 1'b1; // [RULE6]
            end
            if (TX_CORE_MEAS.upd) begin
                tx_fifo_latency.core_cnt <= TX_CORE_MEAS.cnt; // [RULE2]
                tx_fifo_latency.core_vld <= 1'b1; // [RULE6]
            end
        end
    end

    // Receive latency capture
    always_ff @(posedge CLK) begin
        if (RST) begin
            rx_fifo_latency <= '0; // [RULE3] [RULE4] [RULE6]
        end else begin
            if (RX_PCS_MEAS.upd) begin
                rx_fifo_latency.pcs_cnt <= RX_PCS_MEAS.cnt; // [RULE3]
                rx_fifo_latency.pcs_vld <= 1'b1; // [RULE6]
            end
            if (RX_CORE_MEAS.upd) begin
                rx_fifo_latency.core_cnt <= RX_CORE_MEAS.cnt; // [RULE4]
                rx_fifo_latency.core_vld <= 1'b1; // [RULE6]
            end
        end
    end

    // Write channel: address and data accepted in either order, one write at a time
    always_ff @(posedge CLK) begin
        if (RST) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            wst <= FLR_W_IDLE;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= FLR_RESP_OKAY;
        end else begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            case (wst)
                FLR_W_IDLE: begin
                    if (S_AXI_AWVALID && !aw_got && !S_AXI_AWREADY) begin
                        S_AXI_AWREADY <= 1'b1;
                    end
                    if (S_AXI_WVALID && !w_got && !S_AXI_WREADY) begin
                        S_AXI_WREADY <= 1'b1;
                    end
                    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                        aw_got <= 1'b1;
                        aw_addr <= S_AXI_AWADDR;
                    end
                    if (S_AXI_WVALID && S_AXI_WREADY) begin
                        w_got <= 1'b1;
                        w_data <= S_AXI_WDATA;
                        w_strb <= S_AXI_WSTRB;
                    end
                    if (aw_got && w_got) begin
                        S_AXI_BVALID <= 1'b1;
                        // Writable only: interrupt status and mask; all else ignored [RULE11]
                        if (BANK_PRESENT && (aw_addr == FLR_OFF_TX_LAT || aw_addr == FLR_OFF_RX_LAT
                                || aw_addr == FLR_OFF_VER || aw_addr == FLR_OFF_INT_STAT
                                || aw_addr == FLR_OFF_INT_MASK)) begin
                            S_AXI_BRESP <= FLR_RESP_OKAY;
                        end else begin
                            S_AXI_BRESP <= FLR_RESP_SLVERR; // [RULE7]
                        end
                        wst <= FLR_W_RESP;
                    end
                end
                FLR_W_RESP: begin
                    if (S_AXI_BREADY) begin
                        S_AXI_BVALID <= 1'b0;
                        aw_got <= 1'b0;
                        w_got <= 1'b0;
                        wst <= FLR_W_IDLE;
                    end
                end
                default: begin
                    wst <= FLR_W_IDLE;
                end
            endcase
        end
    end

    // Write commit happens in the cycle the response is raised
    assign stat_wr = (wst == FLR_W_IDLE) && aw_got && w_got && w_strb[0] && BANK_PRESENT;

    // Sticky update events; a new update beats a simultaneous clear
    always_ff @(posedge CLK) begin
        if (RST) begin
            int_stat <= 4'h0;
        end else if (stat_wr && aw_addr == FLR_OFF_INT_STAT) begin
            int_stat <= (int_stat & ~w_data[3:0]) | upd_vec;
        end else begin
            int_stat <= int_stat | upd_vec;
        end
    end

    // Mask register, same bit layout as status
    always_ff @(posedge CLK) begin
        if (RST) begin
            int_mask <= FLR_MASK_RST;
        end else if (stat_wr && aw_addr == FLR_OFF_INT_MASK) begin
            int_mask <= w_data[3:0];
        end
    end

    // Registered interrupt level, one cycle behind the status
    always_ff @(posedge CLK) begin
        if (RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(int_stat & int_mask);
        end
    end

    // Read decode; unmapped or absent bank answers SLVERR with zero data
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_rresp = FLR_RESP_OKAY;
        if (!BANK_PRESENT) begin
            next_rresp = FLR_RESP_SLVERR; // [RULE7]
        end else begin
            case (S_AXI_ARADDR)
                FLR_OFF_TX_LAT: next_rdata = flr_pack(tx_fifo_latency); // [RULE11]
                FLR_OFF_RX_LAT: next_rdata = flr_pack(rx_fifo_latency); // [RULE11]
                FLR_OFF_VER: next_rdata = {24'h00_0000, ver_word}; // [RULE8] [RULE11]
                FLR_OFF_INT_STAT: next_rdata = {28'h000_0000, int_stat};
                FLR_OFF_INT_MASK: next_rdata = {28'h000_0000, int_mask};
                default: next_rresp = FLR_RESP_SLVERR;
            endcase
        end
    end

    // Read channel: address taken one cycle after arvalid, data the cycle after
    always_ff @(posedge CLK) begin
        if (RST) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= FLR_RESP_OKAY;
        end else begin
            S_AXI_ARREADY <= 1'b0;
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA <= next_rdata;
                S_AXI_RRESP <= next_rresp;
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end else if (S_AXI_ARVALID && !S_AXI_RVALID && !S_AXI_ARREADY) begin
                S_AXI_ARREADY <= 1'b1;
            end
        end
    end

    // Each strobe loads its count and raises its fresh flag on the next edge
    AST_TXPCS_LOAD: assert property (@(posedge CLK) disable iff (RST) // [RULE1]
        TX_PCS_MEAS.upd |=> tx_fifo_latency.pcs_cnt == $past(TX_PCS_MEAS.cnt) && tx_fifo_latency.pcs_vld)
        else $error("tx pcs count not captured");
    AST_TXCORE_LOAD: assert property (@(posedge CLK) disable iff (RST) // [RULE2]
        TX_CORE_MEAS.upd |=> tx_fifo_latency.core_cnt == $past(TX_CORE_MEAS.cnt))
        else $error("tx core count not captured");
    AST_RXPCS_LOAD: assert property (@(posedge CLK) disable iff (RST) // [RULE3]
        RX_PCS_MEAS.upd |=> rx_fifo_latency.pcs_cnt == $past(RX_PCS_MEAS.cnt))
        else $error("rx pcs count not captured");
    AST_RXCORE_LOAD: assert property (@(posedge CLK) disable iff (RST) // [RULE4]
        RX_CORE_MEAS.upd |=> rx_fifo_latency.core_cnt == $past(RX_CORE_MEAS.cnt))
        else $error("rx core count not captured");
    AST_TXCORE_VLD: assert property (@(posedge CLK) disable iff (RST) // [RULE6]
        TX_CORE_MEAS.upd |=> tx_fifo_latency.core_vld)
        else $error("tx core flag not set");
    AST_RXPCS_VLD: assert property (@(posedge CLK) disable iff (RST) // [RULE6]
        RX_PCS_MEAS.upd |=> rx_fifo_latency.pcs_vld)
        else $error("rx pcs flag not set");
    AST_RXCORE_VLD: assert property (@(posedge CLK) disable iff (RST) // [RULE6]
        RX_CORE_MEAS.upd |=> rx_fifo_latency.core_vld)
        else $error("rx core flag not set");
    AST_VLD_STICKY: assert property (@(posedge CLK) disable iff (RST) // [RULE6]
        rx_fifo_latency.core_vld |=> rx_fifo_latency.core_vld)
        else $error("rx core flag dropped");
    AST_TXPCS_STICKY: assert property (@(posedge CLK) disable iff (RST) // [RULE6]
        tx_fifo_latency.pcs_vld |=> tx_fifo_latency.pcs_vld)
        else $error("tx pcs flag dropped");

    // A count moves only on its own strobe and is stored unscaled
    AST_HOLD: assert property (@(posedge CLK) disable iff (RST) // [RULE1]
        !TX_PCS_MEAS.upd |=> $stable(tx_fifo_latency.pcs_cnt))
        else $error("tx pcs count changed without update");
    AST_TXCORE_HOLD: assert property (@(posedge CLK) disable iff (RST) // [RULE2]
        !TX_CORE_MEAS.upd |=> $stable(tx_fifo_latency.core_cnt))
        else $error("tx core count changed without update");
    AST_RXPCS_HOLD: assert property (@(posedge CLK) disable iff (RST) // [RULE3]
        !RX_PCS_MEAS.upd |=> $stable(rx_fifo_latency.pcs_cnt))
        else $error("rx pcs count changed without update");
    AST_RXCORE_HOLD: assert property (@(posedge CLK) disable iff (RST) // [RULE4]
        !RX_CORE_MEAS.upd |=> $stable(rx_fifo_latency.core_cnt))
        else $error("rx core count changed without update");

    // A bus write aimed at a latency word must leave it alone
    AST_WR_IGNORED: assert property (@(posedge CLK) disable iff (RST) // [RULE11]
        wst == FLR_W_IDLE && aw_got && w_got && (aw_addr == FLR_OFF_TX_LAT || aw_addr == FLR_OFF_RX_LAT)
        && upd_vec == 4'h0 |=> $stable(tx_fifo_latency) && $stable(rx_fifo_latency))
        else $error("write changed a read-only register");

    // Reset clears both latency words on its first edge; no disable, reset is the trigger
    AST_RST_CLEAR: assert property (@(posedge CLK) // [RULE1] [RULE2] [RULE3] [RULE4] [RULE6]
        RST |=> tx_fifo_latency == '0 && rx_fifo_latency == '0)
        else $error("latency word not cleared by reset");

    // Read data mirrors the stored words at their documented bit positions
    AST_TX_READ: assert property (@(posedge CLK) disable iff (RST) // [RULE1] [RULE2]
        S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == FLR_OFF_TX_LAT && BANK_PRESENT
        |=> S_AXI_RDATA[24:16] == $past(tx_fifo_latency.pcs_cnt)
        && S_AXI_RDATA[8:0] == $past(tx_fifo_latency.core_cnt))
        else $error("tx latency read wrong");
    AST_RX_READ: assert property (@(posedge CLK) disable iff (RST) // [RULE3] [RULE4] [RULE6]
        S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == FLR_OFF_RX_LAT && BANK_PRESENT
        |=> S_AXI_RDATA[24:16] == $past(rx_fifo_latency.pcs_cnt)
        && S_AXI_RDATA[8:0] == $past(rx_fifo_latency.core_cnt)
        && S_AXI_RDATA[31] == $past(rx_fifo_latency.pcs_vld) && S_AXI_RDATA[15] == $past(rx_fifo_latency.core_vld))
        else $error("rx latency read wrong");
    AST_VER_READ: assert property (@(posedge CLK) disable iff (RST) // [RULE9]
        S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == FLR_OFF_VER && BANK_PRESENT
        |=> S_AXI_RDATA == 32'h0000_0061)
        else $error("version read wrong");
    AST_VER_FIELDS: assert property (@(posedge CLK) disable iff (RST) // [RULE8]
        S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == FLR_OFF_VER && BANK_PRESENT
        |=> S_AXI_RDATA[7:4] == 4'h6 && S_AXI_RDATA[3:0] == 4'h1 && S_AXI_RDATA[31:8] == 24'h00_0000)
        else $error("version fields misplaced");
    AST_VER_CONST: assert property (@(posedge CLK) ver_word == 8'h61) // [RULE10]
        else $error("version changed");
    AST_RSVD: assert property (@(posedge CLK) disable iff (RST) // [RULE8] [RULE11]
        S_AXI_RVALID && S_AXI_RRESP == FLR_RESP_OKAY |-> S_AXI_RDATA[30:25] == 6'h00 && S_AXI_RDATA[14:9] == 6'h00)
        else $error("reserved bits nonzero");
    AST_UNMAPPED: assert property (@(posedge CLK) disable iff (RST) // [RULE11]
        S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR != FLR_OFF_TX_LAT && S_AXI_ARADDR != FLR_OFF_RX_LAT
        && S_AXI_ARADDR != FLR_OFF_VER && S_AXI_ARADDR != FLR_OFF_INT_STAT && S_AXI_ARADDR != FLR_OFF_INT_MASK
        |=> S_AXI_RRESP == FLR_RESP_SLVERR && S_AXI_RDATA == 32'h0000_0000)
        else $error("unmapped read answered okay");
    AST_ABSENT: assert property (@(posedge CLK) disable iff (RST) // [RULE7]
        S_AXI_RVALID && !BANK_PRESENT |-> S_AXI_RRESP == FLR_RESP_SLVERR)
        else $error("absent bank answered okay");

    // Status bits are sticky, a new event beats a same-cycle clear, the line follows a cycle later
    AST_STAT_SET: assert property (@(posedge CLK) disable iff (RST)
        upd_vec != 4'h0 |=> (int_stat & $past(upd_vec)) == $past(upd_vec))
        else $error("update event lost from status");
    AST_MASK_WR: assert property (@(posedge CLK) disable iff (RST)
        stat_wr && aw_addr == FLR_OFF_INT_MASK |=> int_mask == $past(w_data[3:0]))
        else $error("mask write lost");
    AST_IRQ_LEVEL: assert property (@(posedge CLK) disable iff (RST)
        IRQ == (($past(int_stat) & $past(int_mask)) != 4'h0))
        else $error("interrupt line does not follow status and mask");

    // Handshake timing and refusal while an answer is pending
    AST_RD_LAT: assert property (@(posedge CLK) disable iff (RST)
        S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read response late");
    AST_WR_LAT: assert property (@(posedge CLK) disable iff (RST)
        wst == FLR_W_IDLE && aw_got && w_got |=> S_AXI_BVALID)
        else $error("write response late");
    AST_AR_REFUSED: assert property (@(posedge CLK) disable iff (RST)
        S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("read address taken while data pending");
    AST_W_REFUSED: assert property (@(posedge CLK) disable iff (RST)
        S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("write taken while response pending");

    // Main scenarios reached
    COV_READ: cover property (@(posedge CLK) S_AXI_RVALID && S_AXI_RREADY);
    COV_WRITE: cover property (@(posedge CLK) S_AXI_BVALID && S_AXI_BREADY);
    COV_IRQ: cover property (@(posedge CLK) IRQ);
    COV_ALL_UPD: cover property (@(posedge CLK) upd_vec == 4'hF);
    COV_SLVERR: cover property (@(posedge CLK) S_AXI_RVALID && S_AXI_RRESP == FLR_RESP_SLVERR);
endmodule

// file: include/flr_pkg.sv
// Package for the FIFO latency status register bank.
// Assumes a 32-bit AXI4-Lite slave port on a single 50 MHz clock.
package flr_pkg;
    // Register byte offsets
    localparam logic [7:0] FLR_OFF_TX_LAT = 8'h84;
    localparam logic [7:0] FLR_OFF_RX_LAT = 8'h88;
    localparam logic [7:0] FLR_OFF_VER = 8'h8C;
    localparam logic [7:0] FLR_OFF_INT_STAT = 8'h90;
    localparam logic [7:0] FLR_OFF_INT_MASK = 8'h94;
    // Field positions in the latency registers
    localparam int FLR_PCS_VLD_BIT = 31;
    localparam int FLR_PCS_LSB = 16;
    localparam int FLR_CORE_VLD_BIT = 15;
    localparam int FLR_CORE_LSB = 0;
    localparam int FLR_CNT_W = 9;
    // Latency unit divisor: latency = period * count / 128
    localparam int FLR_STEPS_PER_PERIOD = 128;
    // Version field: major in 7:4, minor in 3:0
    localparam logic [3:0] FLR_VER_MAJOR = 4'h6;
    localparam logic [3:0] FLR_VER_MINOR = 4'h1;
    localparam logic [8:0] FLR_CNT_RST = 9'h000;
    localparam logic [3:0] FLR_MASK_RST = 4'h0;
    // AXI responses
    localparam logic [1:0] FLR_RESP_OKAY = 2'h0;
    localparam logic [1:0] FLR_RESP_SLVERR = 2'h2;

    // One latency measurement: count plus update strobe
    typedef struct packed {
        logic upd;
        logic [8:0] cnt;
    } flr_meas_t;

    // Latency register contents
    typedef struct packed {
        logic pcs_vld;
        logic [8:0] pcs_cnt;
        logic core_vld;
        logic [8:0] core_cnt;
    } flr_lat_t;

    typedef enum logic [1:0] {
        FLR_W_IDLE = 2'b01,
        FLR_W_RESP = 2'b10
    } flr_wst_t;

    // Packs a latency register into a bus word, reserved bits zero
    function automatic logic [31:0] flr_pack(input flr_lat_t r);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[FLR_PCS_VLD_BIT] = r.pcs_vld;
        w[FLR_PCS_LSB +: FLR_CNT_W] = r.pcs_cnt;
        w[FLR_CORE_VLD_BIT] = r.core_vld;
        w[FLR_CORE_LSB +: FLR_CNT_W] = r.core_cnt;
        return w;
    endfunction
endpackage

// file: testbench/tb.sv
// Self-checking bench for the FIFO latency status register bank.
// Assumes flr_regs with its AXI4-Lite slave and the flr_pkg map.
`timescale 1ns/1ps
module tb
    import flr_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    flr_meas_t tx_pcs = '0, tx_core = '0, rx_pcs = '0, rx_core = '0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [31:0] nb_rdata;
    logic [1:0] nb_bresp, nb_rresp;
    logic nb_irq;
    int n_fail = 0;
    int checks = 0;

    flr_regs DUT (.CLK(clk), .RST(rst), .TX_PCS_MEAS(tx_pcs), .TX_CORE_MEAS(tx_core),
        .RX_PCS_MEAS(rx_pcs), .RX_CORE_MEAS(rx_core), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .IRQ(irq));

    // Copy built without the bank shares every input, so its answers land on the same edges as DUT's
    flr_regs #(.BANK_PRESENT(1'b0)) DUT_ABSENT (.CLK(clk), .RST(rst), .TX_PCS_MEAS(tx_pcs),
        .TX_CORE_MEAS(tx_core), .RX_PCS_MEAS(rx_pcs), .RX_CORE_MEAS(rx_core), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(), .S_AXI_BRESP(nb_bresp), .S_AXI_BVALID(), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(), .S_AXI_RDATA(nb_rdata),
        .S_AXI_RRESP(nb_rresp), .S_AXI_RVALID(), .S_AXI_RREADY(rready), .IRQ(nb_irq));

    // 50 MHz clock
    always #10 clk = ~clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        if (n_fail == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Write cycle: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp_resp);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= 4'hF; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 100);
        bready <= 1'b0;
        chk({31'h0, bvalid}, 32'h0000_0001);
        chk({30'h0, bresp}, {30'h0, exp_resp});
        chk({30'h0, nb_bresp}, {30'h0, FLR_RESP_SLVERR});
    endtask

    // Read cycle: rready held until the answer is sampled
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] exp_resp);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 100);
        rready <= 1'b0;
        chk({31'h0, rvalid}, 32'h0000_0001);
        chk(rdata, exp);
        chk({30'h0, rresp}, {30'h0, exp_resp});
        chk(nb_rdata, 32'h0000_0000);
        chk({30'h0, nb_rresp}, {30'h0, FLR_RESP_SLVERR});
    endtask

    // One-cycle update strobes on the measurement inputs selected by sel
    task automatic pulse(input logic [3:0] sel, input logic [8:0] c0, c1, c2, c3);
        @(posedge clk);
        tx_pcs <= '{sel[0], c0}; tx_core <= '{sel[1], c1};
        rx_pcs <= '{sel[2], c2}; rx_core <= '{sel[3], c3};
        @(posedge clk);
        tx_pcs.upd <= 1'b0; tx_core.upd <= 1'b0; rx_pcs.upd <= 1'b0; rx_core.upd <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    // Reset values of every register, version constant included
    task automatic t_reset_values();
        rd(FLR_OFF_TX_LAT, 32'h0000_0000, FLR_RESP_OKAY);
        rd(FLR_OFF_RX_LAT, 32'h0000_0000, FLR_RESP_OKAY);
        rd(FLR_OFF_VER, 32'h0000_0061, FLR_RESP_OKAY);
        rd(FLR_OFF_INT_STAT, 32'h0000_0000, FLR_RESP_OKAY);
        rd(FLR_OFF_INT_MASK, 32'h0000_0000, FLR_RESP_OKAY);
        chk({31'h0, irq}, 32'h0000_0000);
    endtask

    // Boundary counts land in their fields unscaled, flags set, reserved bits zero
    task automatic t_measure();
        pulse(4'hF, 9'h1FF, 9'h001, 9'h100, 9'h0AA);
        rd(FLR_OFF_TX_LAT, 32'h81FF_8001, FLR_RESP_OKAY);
        rd(FLR_OFF_RX_LAT, 32'h8100_80AA, FLR_RESP_OKAY);
        rd(FLR_OFF_INT_STAT, 32'h0000_000F, FLR_RESP_OKAY);
        chk({31'h0, irq}, 32'h0000_0000); // all masked
        // A later update replaces only its own count; flags stay set
        pulse(4'h2, 9'h000, 9'h000, 9'h000, 9'h000);
        rd(FLR_OFF_TX_LAT, 32'h81FF_8000, FLR_RESP_OKAY);
        wr(FLR_OFF_INT_STAT, 32'h0000_000F, FLR_RESP_OKAY);
        rd(FLR_OFF_INT_STAT, 32'h0000_0000, FLR_RESP_OKAY);
    endtask

    // Writes to read-only places change nothing; unmapped address errors
    task automatic t_read_only();
        wr(FLR_OFF_TX_LAT, 32'hFFFF_FFFF, FLR_RESP_OKAY);
        wr(FLR_OFF_VER, 32'h0000_0000, FLR_RESP_OKAY);
        rd(FLR_OFF_TX_LAT, 32'h81FF_8000, FLR_RESP_OKAY);
        rd(FLR_OFF_VER, 32'h0000_0061, FLR_RESP_OKAY);
        wr(8'hA0, 32'hFFFF_FFFF, FLR_RESP_SLVERR);
        rd(8'hA0, 32'h0000_0000, FLR_RESP_SLVERR);
    endtask

    // Masked event stays quiet, unmasked one raises the line, W1C drops it
    task automatic t_interrupt();
        wr(FLR_OFF_INT_MASK, 32'h0000_0001, FLR_RESP_OKAY);
        rd(FLR_OFF_INT_MASK, 32'h0000_0001, FLR_RESP_OKAY);
        pulse(4'h8, 9'h000, 9'h000, 9'h000, 9'h055);
        chk({31'h0, irq}, 32'h0000_0000);
        pulse(4'h1, 9'h033, 9'h000, 9'h000, 9'h000);
        chk({31'h0, irq}, 32'h0000_0001);
        chk({31'h0, nb_irq}, 32'h0000_0000);
        rd(FLR_OFF_INT_STAT, 32'h0000_0009, FLR_RESP_OKAY);
        wr(FLR_OFF_INT_STAT, 32'h0000_0001, FLR_RESP_OKAY);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0000_0000);
        rd(FLR_OFF_INT_STAT, 32'h0000_0008, FLR_RESP_OKAY);
        rd(FLR_OFF_TX_LAT, 32'h8033_8000, FLR_RESP_OKAY);
        rd(FLR_OFF_RX_LAT, 32'h8100_8055, FLR_RESP_OKAY);
    endtask

    // Reset in mid-run clears the counts but not the version
    task automatic t_mid_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(FLR_OFF_TX_LAT, 32'h0000_0000, FLR_RESP_OKAY);
        rd(FLR_OFF_RX_LAT, 32'h0000_0000, FLR_RESP_OKAY);
        rd(FLR_OFF_VER, 32'h0000_0061, FLR_RESP_OKAY);
        rd(FLR_OFF_INT_MASK, 32'h0000_0000, FLR_RESP_OKAY);
        rd(FLR_OFF_INT_STAT, 32'h0000_0000, FLR_RESP_OKAY);
        chk({31'h0, irq}, 32'h0000_0000);
    endtask

    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset_values();
        t_measure();
        t_read_only();
        t_interrupt();
        t_mid_reset();
        results();
    end

    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        results();
    end
endmodule
